// *** logic/srtc_pkg.sv ***
// constants shared by the signal routing fabric and its type converter
// assumes one 100 MHz clock; configuration arrives through a plain register port
package srtc_pkg;

	// fabric size
	localparam int N_SRC   = 7;
	localparam int N_SNK   = 8;
	localparam int N_CANRX = 2;
	localparam int N_CANTX = 5;

	// source indices (select code is index plus one, zero is not connected)
	localparam int SRC_CANRX0 = 0;
	localparam int SRC_LINRX  = 2;
	localparam int SRC_BIN    = 3;
	localparam int SRC_CONST0 = 4;
	localparam int SRC_CONST1 = 5;
	localparam int SRC_AUX    = 6;

	// sink indices
	localparam int SNK_CANTX0 = 0;
	localparam int SNK_BIN_A  = 5;
	localparam int SNK_BIN_B  = 6;
	localparam int SNK_LINTX  = 7;

	// register offsets (word index on the register port)
	localparam logic [7:0] ADDR_ROLE    = 8'h00;
	localparam logic [7:0] ADDR_BAUD    = 8'h01;
	localparam logic [7:0] ADDR_TICK    = 8'h02;
	localparam logic [7:0] ADDR_STATUS  = 8'h03;
	localparam logic [7:0] ADDR_CONST0  = 8'h04;
	localparam logic [7:0] ADDR_CONST1  = 8'h05;
	localparam logic [7:0] ADDR_SRCTYPE = 8'h06;
	localparam logic [7:0] ADDR_BINFUNC = 8'h07;
	localparam logic [7:0] ADDR_SINKCFG = 8'h10;
	localparam logic [7:0] ADDR_SINKDEF = 8'h18;
	localparam logic [7:0] ADDR_SINKVAL = 8'h20;
	localparam logic [7:0] ADDR_SRCVAL  = 8'h28;

	// sink configuration field positions
	localparam int SCFG_SEL_LSB  = 0;
	localparam int SCFG_CONT_BIT = 4;
	localparam int SCFG_DEF_BIT  = 8;

	// reset values and limits
	localparam logic [31:0] BAUD_RST  = 32'h0000_4B00;
	localparam logic [31:0] BAUD_MIN  = 32'h0000_0960;
	localparam logic [31:0] BAUD_MAX  = 32'h0000_4E20;
	localparam logic [31:0] TICK_RST  = 32'h0000_000A;
	localparam logic [31:0] TICK_MIN  = 32'h0000_0001;
	localparam logic [31:0] TICK_MAX  = 32'h0000_2710;
	localparam logic [31:0] DISC_MAX  = 32'hFFFF_FFFF;
	localparam logic [6:0]  SRC_CONT_MASK = 7'h37;
	localparam logic [6:0]  SRC_VALID_RST = 7'h70;

	// schedule tick timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_IN_NS      = 1000000;
	localparam int CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;

	// node role
	typedef enum logic [1:0] {
		ROLE_UNDEF  = 2'h0,
		ROLE_MASTER = 2'h1,
		ROLE_SLAVE  = 2'h2
	} srtc_role_t;

	// two-operand functions
	localparam logic [2:0] BIN_AND = 3'h0;
	localparam logic [2:0] BIN_OR  = 3'h1;
	localparam logic [2:0] BIN_XOR = 3'h2;
	localparam logic [2:0] BIN_ADD = 3'h3;
	localparam logic [2:0] BIN_SUB = 3'h4;
	localparam logic [2:0] BIN_MAX = 3'h5;
	localparam logic [2:0] BIN_MIN = 3'h6;

endpackage

// *** logic/srtc_conv.sv ***
// type converter for one routed signal input
// assumes single precision floats for continuous values, unsigned words for discrete
`timescale 1ns/10ps

module srtc_conv
	import srtc_pkg::*;
(
	// routed source
	input  wire logic [31:0] srcVal,
	input  wire logic        srcValid,
	input  wire logic        srcCont,
	input  wire logic        connected,
	// sink configuration
	input  wire logic        sinkCont,
	input  wire logic        defEn,
	input  wire logic [31:0] defVal,
	// delivered value
	output logic      [31:0] outVal,
	output logic             outValid
);

	// unsigned to float, mantissa truncated toward zero
	function automatic logic [31:0] u2f(input logic [31:0] u);
		logic [4:0]  msb;
		logic [31:0] norm;
		msb = 5'h0;
		for (int i = 0; i < 32; i++) begin
			if (u[i]) begin
				msb = 5'(i);
			end
		end
		norm = u << (5'h1F - msb);
		if (u == 32'h0) begin
			u2f = 32'h0;
		end else begin
			u2f = {1'b0, 8'h7F + {3'h0, msb}, norm[30:8]};
		end
	endfunction

	// float to unsigned: truncate, clamp negatives, saturate above range
	function automatic logic [31:0] f2u(input logic [31:0] f);
		logic [7:0]  e;
		logic [31:0] mant;
		e    = f[30:23];
		mant = {8'h0, 1'b1, f[22:0]};
		if (e == 8'hFF && f[22:0] != 23'h0) begin
			f2u = 32'h0; // nan has no numeric meaning
		end else if (f[31]) begin
			f2u = 32'h0;
		end else if (e < 8'h7F) begin
			f2u = 32'h0;
		end else if (e > 8'h9E) begin
			f2u = DISC_MAX;
		end else if (e >= 8'h96) begin
			f2u = mant << (e - 8'h96);
		end else begin
			f2u = mant >> (8'h96 - e);
		end
	endfunction

	// undefined never becomes a number unless a default is configured
	always_comb begin
		if (!connected || !srcValid) begin
			outValid = defEn;
			outVal   = defEn ? defVal : 32'h0;
		end else if (srcCont == sinkCont) begin
			outValid = 1'b1;
			outVal   = srcVal;
		end else if (sinkCont) begin
			outValid = 1'b1;
			outVal   = u2f(srcVal);
		end else begin
			outValid = 1'b1;
			outVal   = f2u(srcVal);
		end
	end

endmodule

// *** logic/srtc_fabric.sv ***
// signal routing fabric with automatic type conversion and serial node settings
// assumes receive strobes and data come from logic on the same clock
`timescale 1ns/10ps

module srtc_fabric
	import srtc_pkg::*;
#(
	parameter int CYCLES_PER_MS = CYC_PER_MS
) (
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	// register port
	input  wire logic [7:0]              regAddr,
	input  wire logic [31:0]             regWrData,
	input  wire logic                    regWr,
	input  wire logic                    regRd,
	output logic      [31:0]             regRdData,
	// CAN receive signals
	input  wire logic [N_CANRX-1:0]       canRxStb,
	input  wire logic [N_CANRX-1:0][31:0] canRxData,
	// CAN transmit message
	output logic      [N_CANTX-1:0][31:0] canTxValue,
	output logic      [N_CANTX-1:0]       canTxValid,
	// serial signal block
	input  wire logic                    linRxStb,
	input  wire logic [31:0]             linRxData,
	output logic      [31:0]             linTxValue,
	output logic                         linTxValid,
	// serial node settings
	output srtc_role_t                   nodeRole,
	output logic                         nodeEnable,
	output logic      [15:0]             baudRate,
	output logic      [13:0]             tickTime,
	output logic                         schedTick
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		srtc_role_t               role;
		logic                     nodeEn;
		logic [15:0]              baud;
		logic [13:0]              tick;
		logic [N_SRC-1:0]         srcCont;
		logic [2:0]               binFunc;
		logic [N_SNK-1:0][2:0]    sinkSel;
		logic [N_SNK-1:0]         sinkCont;
		logic [N_SNK-1:0]         defEn;
		logic [N_SNK-1:0][31:0]   defVal;
		logic [N_SRC-1:0][31:0]   srcVal;
		logic [N_SRC-1:0]         srcValid;
		logic [N_SNK-1:0][31:0]   sinkVal;
		logic [N_SNK-1:0]         sinkValid;
		logic                     linTxVld;
		logic [16:0]              cycCnt;
		logic [13:0]              msCnt;
		logic                     tickPulse;
		logic [31:0]              rdData;
	} srtc_state_t;

	srtc_state_t s_r;
	srtc_state_t s_nxt;

	// routed views per sink
	logic [N_SNK-1:0][31:0] muxVal;
	logic [N_SNK-1:0]       muxValid;
	logic [N_SNK-1:0]       muxCont;
	logic [N_SNK-1:0]       muxConn;
	logic [N_SNK-1:0][31:0] convVal;
	logic [N_SNK-1:0]       convValid;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// bank of eight words, shared by read and write decode
	function automatic logic inBank(input logic [7:0] a, input logic [7:0] base);
		inBank = (a[7:3] == base[7:3]);
	endfunction

	// discrete two-operand functions; add saturates, subtract clamps at zero
	function automatic logic [31:0] binOp(input logic [2:0] f, input logic [31:0] a,
		input logic [31:0] b);
		logic [32:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		case (f)
			BIN_AND: binOp = a & b;
			BIN_OR:  binOp = a | b;
			BIN_XOR: binOp = a ^ b;
			BIN_ADD: binOp = sum[32] ? DISC_MAX : sum[31:0];
			BIN_SUB: binOp = (a > b) ? a - b : 32'h0;
			BIN_MAX: binOp = (a > b) ? a : b;
			BIN_MIN: binOp = (a < b) ? a : b;
			default: binOp = 32'h0;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// routing and conversion
	// ---------------------------------------------------------------
	for (genvar g = 0; g < N_SNK; g++) begin : gSink
		logic [2:0] idx;
		// select code zero is the unconnected input
		assign muxConn[g]  = (s_r.sinkSel[g] != 3'h0);
		assign idx         = muxConn[g] ? s_r.sinkSel[g] - 3'h1 : 3'h0;
		// any number of sinks may read the same source word
		assign muxVal[g]   = s_r.srcVal[idx];
		assign muxValid[g] = muxConn[g] & s_r.srcValid[idx];
		assign muxCont[g]  = s_r.srcCont[idx];

		srtc_conv uConv (
			.srcVal   (muxVal[g]),
			.srcValid (muxValid[g]),
			.srcCont  (muxCont[g]),
			.connected(muxConn[g]),
			.sinkCont (s_r.sinkCont[g]),
			.defEn    (s_r.defEn[g]),
			.defVal   (s_r.defVal[g]),
			.outVal   (convVal[g]),
			.outValid (convValid[g])
		);
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt           = s_r;
		s_nxt.rdData    = 32'h0;
		s_nxt.tickPulse = 1'b0;

		// configuration writes; out of range values are dropped whole
		if (regWr) begin
			if (regAddr == ADDR_ROLE) begin
				if (regWrData[1:0] != 2'h3) begin
					s_nxt.role = srtc_role_t'(regWrData[1:0]);
				end
			end else if (regAddr == ADDR_BAUD) begin
				if (regWrData >= BAUD_MIN && regWrData <= BAUD_MAX) begin
					s_nxt.baud = regWrData[15:0];
				end
			end else if (regAddr == ADDR_TICK) begin
				if (regWrData >= TICK_MIN && regWrData <= TICK_MAX) begin
					s_nxt.tick = regWrData[13:0];
				end
			end else if (regAddr == ADDR_CONST0) begin
				s_nxt.srcVal[SRC_CONST0] = regWrData;
			end else if (regAddr == ADDR_CONST1) begin
				s_nxt.srcVal[SRC_CONST1] = regWrData;
			end else if (regAddr == ADDR_SRCTYPE) begin
				// function and auxiliary outputs are always discrete
				s_nxt.srcCont = regWrData[6:0] & SRC_CONT_MASK;
			end else if (regAddr == ADDR_BINFUNC) begin
				s_nxt.binFunc = regWrData[2:0];
			end else if (inBank(regAddr, ADDR_SINKCFG)) begin
				s_nxt.sinkSel[regAddr[2:0]]  = regWrData[SCFG_SEL_LSB +: 3];
				s_nxt.sinkCont[regAddr[2:0]] = regWrData[SCFG_CONT_BIT];
				s_nxt.defEn[regAddr[2:0]]    = regWrData[SCFG_DEF_BIT];
			end else if (inBank(regAddr, ADDR_SINKDEF)) begin
				s_nxt.defVal[regAddr[2:0]] = regWrData;
			end
		end

		// readback of every setting plus live values; unmapped reads zero
		if (regRd) begin
			if (regAddr == ADDR_ROLE) begin
				s_nxt.rdData = {30'h0, s_r.role};
			end else if (regAddr == ADDR_BAUD) begin
				s_nxt.rdData = {16'h0, s_r.baud};
			end else if (regAddr == ADDR_TICK) begin
				s_nxt.rdData = {18'h0, s_r.tick};
			end else if (regAddr == ADDR_STATUS) begin
				s_nxt.rdData = {9'h0, s_r.srcValid, s_r.sinkValid, 7'h0, s_r.nodeEn};
			end else if (regAddr == ADDR_CONST0) begin
				s_nxt.rdData = s_r.srcVal[SRC_CONST0];
			end else if (regAddr == ADDR_CONST1) begin
				s_nxt.rdData = s_r.srcVal[SRC_CONST1];
			end else if (regAddr == ADDR_SRCTYPE) begin
				s_nxt.rdData = {25'h0, s_r.srcCont};
			end else if (regAddr == ADDR_BINFUNC) begin
				s_nxt.rdData = {29'h0, s_r.binFunc};
			end else if (inBank(regAddr, ADDR_SINKCFG)) begin
				s_nxt.rdData = {23'h0, s_r.defEn[regAddr[2:0]], 3'h0,
					s_r.sinkCont[regAddr[2:0]], 1'b0, s_r.sinkSel[regAddr[2:0]]};
			end else if (inBank(regAddr, ADDR_SINKDEF)) begin
				s_nxt.rdData = s_r.defVal[regAddr[2:0]];
			end else if (inBank(regAddr, ADDR_SINKVAL)) begin
				s_nxt.rdData = s_r.sinkVal[regAddr[2:0]];
			end else if (inBank(regAddr, ADDR_SRCVAL)) begin
				if (regAddr[2:0] < 3'(N_SRC)) begin
					s_nxt.rdData = s_r.srcVal[regAddr[2:0]];
				end
			end
		end

		s_nxt.nodeEn = (s_nxt.role != ROLE_UNDEF);

		// CAN receive outputs take the word in the cycle it arrives
		for (int i = 0; i < N_CANRX; i++) begin
			if (canRxStb[i]) begin
				s_nxt.srcVal[SRC_CANRX0 + i]   = canRxData[i];
				s_nxt.srcValid[SRC_CANRX0 + i] = 1'b1;
			end
		end

		// a switched off node shows no received signal
		if (!s_nxt.nodeEn) begin
			s_nxt.srcValid[SRC_LINRX] = 1'b0;
		end else if (linRxStb) begin
			s_nxt.srcVal[SRC_LINRX]   = linRxData;
			s_nxt.srcValid[SRC_LINRX] = 1'b1;
		end

		// function output is undefined while either operand is
		s_nxt.srcValid[SRC_BIN] = s_r.sinkValid[SNK_BIN_A] & s_r.sinkValid[SNK_BIN_B];
		s_nxt.srcVal[SRC_BIN]   = s_nxt.srcValid[SRC_BIN] ?
			binOp(s_r.binFunc, s_r.sinkVal[SNK_BIN_A], s_r.sinkVal[SNK_BIN_B]) :
			32'h0;

		// auxiliary output reports whether the node is active
		s_nxt.srcVal[SRC_AUX] = {31'h0, s_r.nodeEn};

		// sinks register the converted word and its flag together
		for (int i = 0; i < N_SNK; i++) begin
			s_nxt.sinkVal[i]   = convVal[i];
			s_nxt.sinkValid[i] = convValid[i];
		end
		s_nxt.linTxVld = convValid[SNK_LINTX] & s_nxt.nodeEn;

		// millisecond prescaler then tick divider, idle unless master; leaving master drops a due tick
		if (s_r.role == ROLE_MASTER && s_nxt.role == ROLE_MASTER) begin
			if (s_r.cycCnt == 17'(CYCLES_PER_MS - 1)) begin
				s_nxt.cycCnt = 17'h0;
				// >= keeps a shortened tick from overrunning
				if (s_r.msCnt >= s_r.tick - 14'h1) begin
					s_nxt.msCnt     = 14'h0;
					s_nxt.tickPulse = 1'b1;
				end else begin
					s_nxt.msCnt = s_r.msCnt + 14'h1;
				end
			end else begin
				s_nxt.cycCnt = s_r.cycCnt + 17'h1;
			end
		end else begin
			s_nxt.cycCnt = 17'h0;
			s_nxt.msCnt  = 14'h0;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_r          <= '0;
			s_r.baud     <= BAUD_RST[15:0];
			s_r.tick     <= TICK_RST[13:0];
			s_r.srcValid <= SRC_VALID_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state flops
	assign regRdData  = s_r.rdData;
	assign linTxValue = s_r.sinkVal[SNK_LINTX];
	assign linTxValid = s_r.linTxVld;
	assign nodeRole   = s_r.role;
	assign nodeEnable = s_r.nodeEn;
	assign baudRate   = s_r.baud;
	assign tickTime   = s_r.tick;
	assign schedTick  = s_r.tickPulse;
	for (genvar g = 0; g < N_CANTX; g++) begin : gTx
		assign canTxValue[g] = s_r.sinkVal[SNK_CANTX0 + g];
		assign canTxValid[g] = s_r.sinkValid[SNK_CANTX0 + g];
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_fanout;
		muxConn[0] && s_r.sinkSel[0] == s_r.sinkSel[1] |-> muxVal[0] == muxVal[1]
			&& muxValid[0] == muxValid[1] && muxCont[0] == muxCont[1];
	endproperty
	a_fanout: assert property (p_fanout) else $error("fan-out sinks differ");

	property p_unconn;
		!muxConn[0] && !s_r.defEn[0] |=> !canTxValid[0];
	endproperty
	a_unconn: assert property (p_unconn) else $error("unconnected sink valid");

	property p_default;
		!muxConn[2] && s_r.defEn[2] |=> canTxValid[2] && canTxValue[2] == $past(s_r.defVal[2]);
	endproperty
	a_default: assert property (p_default) else $error("default not used");

	property p_same;
		muxValid[0] && muxCont[0] == s_r.sinkCont[0]
			|=> canTxValid[0] && canTxValue[0] == $past(muxVal[0]);
	endproperty
	a_same: assert property (p_same) else $error("same type not passed");

	property p_neg;
		muxValid[1] && muxCont[1] && !s_r.sinkCont[1] && muxVal[1][31] |=> canTxValue[1] == 32'h0;
	endproperty
	a_neg: assert property (p_neg) else $error("negative not zero");

	property p_sat;
		muxValid[1] && muxCont[1] && !s_r.sinkCont[1] && !muxVal[1][31]
			&& muxVal[1][30:23] > 8'h9E && muxVal[1][30:23] != 8'hFF
			|=> canTxValue[1] == 32'hFFFF_FFFF;
	endproperty
	a_sat: assert property (p_sat) else $error("no saturation");

	property p_u2f;
		muxValid[0] && !muxCont[0] && s_r.sinkCont[0] |=> !canTxValue[0][31] && canTxValid[0];
	endproperty
	a_u2f: assert property (p_u2f) else $error("negative float from discrete");

	property p_canrx;
		canRxStb[0] |=> s_r.srcValid[SRC_CANRX0] && s_r.srcVal[SRC_CANRX0] == $past(canRxData[0]);
	endproperty
	a_canrx: assert property (p_canrx) else $error("receive not captured");

	property p_off;
		!nodeEnable |-> !schedTick && !linTxValid;
	endproperty
	a_off: assert property (p_off) else $error("disabled node active");

	property p_tick;
		schedTick |-> $past(s_r.role) == ROLE_MASTER && !$past(schedTick);
	endproperty
	a_tick: assert property (p_tick) else $error("tick outside master");

	property p_baud;
		regWr && regAddr == ADDR_BAUD && (regWrData < BAUD_MIN || regWrData > BAUD_MAX)
			|=> $stable(baudRate);
	endproperty
	a_baud: assert property (p_baud) else $error("bad bit rate accepted");

	property p_rd;
		regRd && regAddr == ADDR_TICK |=> regRdData == {18'h0, $past(tickTime)}
			##1 ($past(regRd) || regRdData == 32'h0);
	endproperty
	a_rd: assert property (p_rd) else $error("tick readback wrong");

	c_conv: cover property (muxValid[1] && muxCont[1] != s_r.sinkCont[1]);
	c_def:  cover property (!muxValid[5] && s_r.defEn[5] ##1 s_r.srcValid[SRC_BIN]);
	c_tick: cover property (schedTick);

endmodule

// *** tb/srtc_far_end.sv ***
// far-side model: CAN receive blocks and serial receiver feeding the fabric
// assumes its tasks are called from the bench, one word at a time
`timescale 1ns/10ps
module srtc_far_end
	import srtc_pkg::*;
(
	// clock
	input  wire logic                     clock,
	// words toward the fabric
	output logic      [N_CANRX-1:0]       canRxStb,
	output logic      [N_CANRX-1:0][31:0] canRxData,
	output logic                          linRxStb,
	output logic      [31:0]              linRxData
);
	// quiet at time zero
	initial begin
		canRxStb  = '0;
		canRxData = '0;
		linRxStb  = 1'b0;
		linRxData = 32'h0000_0000;
	end

	// one-cycle arrival; data then inverted so a stale word never looks held
	task automatic sendCan(input int i, input logic [31:0] d);
		@(posedge clock);
		canRxStb[i]  <= 1'b1;
		canRxData[i] <= d;
		@(posedge clock);
		canRxStb[i]  <= 1'b0;
		canRxData[i] <= ~d;
	endtask

	// serial word received from the bus
	task automatic sendLin(input logic [31:0] d);
		@(posedge clock);
		linRxStb  <= 1'b1;
		linRxData <= d;
		@(posedge clock);
		linRxStb  <= 1'b0;
		linRxData <= ~d;
	endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the signal routing fabric
// assumes the far-side model supplies every received word
`timescale 1ns/10ps
module tb;
	import srtc_pkg::*;
	localparam int CPM = 4; // short millisecond keeps tick tests brief
	// clock, reset and register port
	logic                     clock     = 1'b0;
	logic                     rst_n     = 1'b0;
	logic [7:0]               regAddr   = 8'h00;
	logic [31:0]              regWrData = 32'h0000_0000;
	logic                     regWr     = 1'b0;
	logic                     regRd     = 1'b0;
	logic [31:0]              regRdData;
	// far side and fabric outputs
	logic [N_CANRX-1:0]       canRxStb;
	logic [N_CANRX-1:0][31:0] canRxData;
	logic                     linRxStb;
	logic [31:0]              linRxData;
	logic [N_CANTX-1:0][31:0] canTxValue;
	logic [N_CANTX-1:0]       canTxValid;
	logic [31:0]              linTxValue;
	logic                     linTxValid;
	srtc_role_t               nodeRole;
	logic                     nodeEnable;
	logic [15:0]              baudRate;
	logic [13:0]              tickTime;
	logic                     schedTick;
	int                       errorCnt   = 0;
	int                       checksDone = 0;
	int                       cyc        = 0;
	int                       n;
	// float inputs and their truncated, saturated or clamped words
	logic [31:0] fIn [5] = '{32'h40B0_0000, 32'hC000_0000, 32'h4F80_0000, 32'h3F00_0000,
		32'h4F7F_FFFF};
	logic [31:0] fOut[5] = '{32'h0000_0005, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000,
		32'hFFFF_FF00};
	// two-operand results for a = FFFFFFF0, b = 20, codes 0..7
	logic [31:0] bExp[8] = '{32'h0000_0020, 32'hFFFF_FFF0, 32'hFFFF_FFD0, 32'hFFFF_FFFF,
		32'hFFFF_FFD0, 32'hFFFF_FFF0, 32'h0000_0020, 32'h0000_0000};

	always #5 clock = ~clock;

	srtc_fabric #(.CYCLES_PER_MS(CPM)) srtc_fabric_inst (.clock(clock), .rst_n(rst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .canRxStb(canRxStb), .canRxData(canRxData),
		.canTxValue(canTxValue), .canTxValid(canTxValid), .linRxStb(linRxStb),
		.linRxData(linRxData), .linTxValue(linTxValue), .linTxValid(linTxValid),
		.nodeRole(nodeRole), .nodeEnable(nodeEnable), .baudRate(baudRate),
		.tickTime(tickTime), .schedTick(schedTick));

	srtc_far_end srtc_far_end_inst (.clock(clock), .canRxStb(canRxStb),
		.canRxData(canRxData), .linRxStb(linRxStb), .linRxData(linRxData));

	// --------------------------------
	// access and compare tasks
	// --------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errorCnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regWr     <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clock);
		regWr <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRd <= 1'b0;
		#1 chk(regRdData, e);
	endtask

	task automatic settle();
		repeat (4) @(posedge clock);
		#1;
	endtask

	task automatic ticks(input int c);
		n = 0;
		repeat (c) begin
			@(posedge clock);
			#1 if (schedTick === 1'b1) n++;
		end
	endtask

	// --------------------------------
	// verdict and hang guard
	// --------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", checksDone, errorCnt);
		if (errorCnt == 0 && checksDone > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ceiling well above the few hundred cycles the tests need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			errorCnt++;
			results();
		end
	end

	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		chk(32'(baudRate), 32'h0000_4B00);
		chk(32'(tickTime), 32'h0000_000A);
		chk(32'(nodeRole), 32'h0000_0000);
		chk(32'(nodeEnable), 32'h0000_0000);
		rdChk(ADDR_ROLE, 32'h0000_0000);
		rdChk(ADDR_STATUS, 32'h0070_0000);
		// limits: out-of-range writes dropped, edges kept
		wr(ADDR_BAUD, 32'h0000_095F);
		rdChk(ADDR_BAUD, 32'h0000_4B00);
		wr(ADDR_BAUD, 32'h0000_0960);
		rdChk(ADDR_BAUD, 32'h0000_0960);
		wr(ADDR_BAUD, 32'h0000_4E21);
		rdChk(ADDR_BAUD, 32'h0000_0960);
		wr(ADDR_BAUD, 32'h0000_4E20);
		#1 chk(32'(baudRate), 32'h0000_4E20);
		wr(ADDR_TICK, 32'h0000_0000);
		rdChk(ADDR_TICK, 32'h0000_000A);
		wr(ADDR_TICK, 32'h0000_2711);
		rdChk(ADDR_TICK, 32'h0000_000A);
		wr(ADDR_TICK, 32'h0000_2710);
		rdChk(ADDR_TICK, 32'h0000_2710);
		wr(ADDR_ROLE, 32'h0000_0003);
		rdChk(ADDR_ROLE, 32'h0000_0000);
		wr(8'h3F, 32'hFFFF_FFFF);
		rdChk(8'h3F, 32'h0000_0000);
		$display("test settings done");
		// discrete source fanned out to a float sink and a word sink
		wr(ADDR_SINKCFG, 32'h0000_0011);
		wr(ADDR_SINKCFG + 8'h01, 32'h0000_0001);
		srtc_far_end_inst.sendCan(0, 32'h0000_0005);
		settle();
		chk(canTxValue[0], 32'h40A0_0000);
		chk(canTxValue[1], 32'h0000_0005);
		chk(32'(canTxValid[1:0]), 32'h0000_0003);
		srtc_far_end_inst.sendCan(0, 32'h0100_0001);
		settle();
		chk(canTxValue[0], 32'h4B80_0000);
		// source turned continuous: raw to float sink, converted to word sink
		wr(ADDR_SRCTYPE, 32'h0000_0001);
		for (int i = 0; i < 5; i++) begin
			srtc_far_end_inst.sendCan(0, fIn[i]);
			settle();
			chk(canTxValue[0], fIn[i]);
			chk(canTxValue[1], fOut[i]);
		end
		$display("test conversion done");
		// unconnected, never-received and defaulted inputs
		wr(ADDR_SINKCFG + 8'h03, 32'h0000_0002);
		settle();
		chk(32'(canTxValid[3:2]), 32'h0000_0000);
		wr(ADDR_SINKDEF + 8'h02, 32'h0000_1234);
		wr(ADDR_SINKCFG + 8'h02, 32'h0000_0100);
		settle();
		chk(canTxValue[2], 32'h0000_1234);
		chk(32'(canTxValid[2]), 32'h0000_0001);
		$display("test undefined done");
		// two-operand block fed by the two constants
		wr(ADDR_CONST0, 32'hFFFF_FFF0);
		wr(ADDR_CONST1, 32'h0000_0020);
		wr(ADDR_SINKCFG + 8'h05, 32'h0000_0005);
		wr(ADDR_SINKCFG + 8'h06, 32'h0000_0006);
		wr(ADDR_SINKCFG + 8'h04, 32'h0000_0004);
		rdChk(ADDR_SRCVAL + 8'h04, 32'hFFFF_FFF0);
		for (int f = 0; f < 8; f++) begin
			wr(ADDR_BINFUNC, 32'(f));
			settle();
			chk(canTxValue[4], bExp[f]);
		end
		chk(32'(canTxValid[4]), 32'h0000_0001);
		rdChk(ADDR_SINKVAL + 8'h05, 32'hFFFF_FFF0);
		$display("test function done");
		// node role, aux output, serial path and schedule tick
		wr(ADDR_SINKCFG + 8'h03, 32'h0000_0007);
		wr(ADDR_SINKCFG + 8'h07, 32'h0000_0003);
		wr(ADDR_TICK, 32'h0000_0002);
		srtc_far_end_inst.sendLin(32'h0000_0077);
		settle();
		chk(32'(linTxValid), 32'h0000_0000);
		chk(canTxValue[3], 32'h0000_0000);
		wr(ADDR_ROLE, 32'h0000_0001);
		ticks(76);
		chk(32'(n), 32'h0000_0009);
		chk(32'(nodeEnable), 32'h0000_0001);
		chk(32'(nodeRole), 32'h0000_0001);
		chk(canTxValue[3], 32'h0000_0001);
		srtc_far_end_inst.sendLin(32'h0000_0077);
		settle();
		chk(linTxValue, 32'h0000_0077);
		chk(32'(linTxValid), 32'h0000_0001);
		wr(ADDR_ROLE, 32'h0000_0002);
		ticks(40);
		chk(32'(n), 32'h0000_0000);
		wr(ADDR_ROLE, 32'h0000_0000);
		settle();
		chk(32'(linTxValid), 32'h0000_0000);
		$display("test node done");
		results();
	end
endmodule
